// File: gp_adc_pkg.sv
`default_nettype none
package gp_adc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MAN_CTL = 8'h51;
    localparam logic [7:0] IDX_AUTO_CTL = 8'h52;
    localparam logic [7:0] IDX_RES_LO = 8'h53;
    localparam logic [7:0] IDX_RES_HI = 8'h54;
    localparam logic [7:0] IDX_SUPPLY_AUTO_RESULT = 8'h55;
    localparam logic [7:0] IDX_VDD_THR = 8'h56;
    localparam logic [7:0] IDX_ICH_AVG = 8'h57;
    localparam logic [7:0] IDX_ICH_THD = 8'h58;
    localparam logic [7:0] IDX_ICH_END = 8'h59;
    localparam logic [7:0] IDX_BATTERY_TEMP_RESULT = 8'h5A;
    localparam logic [7:0] IDX_BATTERY_TEMP_INPUT_HI = 8'h5B;
    localparam logic [7:0] IDX_BATTERY_TEMP_INPUT_RS = 8'h5C;
    localparam logic [7:0] IDX_BATTERY_TEMP_INPUT_LO = 8'h5D;
    localparam logic [7:0] IDX_T_OFF = 8'h5E;
    localparam logic [7:0] IDX_EVT = 8'h5F;
    localparam logic [7:0] IDX_MASK = 8'h60;
    // Field positions
    localparam int GO_BIT = 4;
    localparam int AC_SUPPLY = 0;
    localparam int AC_AUX4 = 1;
    localparam int AC_AUX5 = 2;
    localparam int AC_AUX6 = 3;
    localparam int AC_AUX4_SRC = 4;
    localparam int AC_BATTERY_TEMP_INPUT_ON = 5;
    localparam int AC_FAST = 6;
    localparam int AC_COMP = 7;
    // Event bits
    localparam int EV_MAN = 0;
    localparam int EV_VDD_LOW = 1;
    localparam int EV_ICH_RED = 2;
    localparam int EV_ICH_END = 3;
    localparam int EV_HOT = 4;
    localparam int EV_COLD = 5;
    localparam int NUM_EV = 6;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [NUM_EV-1:0] RST_MASK = 6'h00;
    // Converter channel codes
    localparam logic [3:0] CH_SUPPLY = 4'h0;
    localparam logic [3:0] CH_CHARGE = 4'h1;
    localparam logic [3:0] CH_BATTERY_TEMP_INPUT = 4'h2;
    localparam logic [3:0] CH_AUX4 = 4'h4;
    localparam logic [3:0] CH_AUX5 = 4'h5;
    localparam logic [3:0] CH_AUX6 = 4'h6;
    // Auto sequence slots
    localparam logic [2:0] SLOT_SUPPLY = 3'h0;
    localparam logic [2:0] SLOT_CHARGE = 3'h1;
    localparam logic [2:0] SLOT_BATTERY_TEMP_INPUT = 3'h2;
    localparam logic [2:0] SLOT_AUX4 = 3'h3;
    localparam logic [2:0] SLOT_AUX5 = 3'h4;
    localparam logic [2:0] SLOT_AUX6 = 3'h5;
    localparam logic [2:0] SLOT_END = 3'h6;
    // Timing
    localparam longint unsigned CLK_KHZ = 250000;
    localparam longint unsigned SLOW_MS = 10;
    localparam longint unsigned FAST_MS = 1;
    localparam longint unsigned REFRESH_MS = 10240;
    localparam longint unsigned SLOW_CYC = SLOW_MS * CLK_KHZ;
    localparam longint unsigned FAST_CYC = FAST_MS * CLK_KHZ;
    localparam longint unsigned REFRESH_CYC = REFRESH_MS * CLK_KHZ;
    localparam int ACC_W = 18;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_AUTO = 2'b01,
        ST_MAN = 2'b10
    } conv_state_t;
endpackage
`default_nettype wire

// File: period_tick.sv
`default_nettype none
module period_tick #(
    parameter int W = 32
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] period,
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } tick_state_t;
    tick_state_t q, d;
    always_comb begin
        d = q;
        d.tick = 1'b0;
        // A shortened period takes effect at once
        if (q.cnt + W'(1) >= period) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + W'(1);
        end
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign tick = q.tick;
endmodule
`default_nettype wire

// File: gp_adc_regs.sv
// The AHB-Lite interface to the registers was decided locally.
`default_nettype none
// Contract
// - Four-bit channel field picks the converter input for manual conversions.
// - Writing one to go starts one conversion; hardware clears it when done.
// - Auto-control bit 0 includes the supply rail in the auto sequence.
// - Bits 1..3 include auxiliary inputs four, five, six in the sequence.
// - Bit 4 switches the aux four current source on or off.
// - Bit 5 clear: battery source on one slot early, off after; set: always on.
// - Bit 6 picks sequence period: 10 ms when clear, 1 ms when set.
// - Bit 7 enables the aux five fixed-level comparator.
// - Manual result: two low bits in one register, eight high bits next.
// - Latest auto supply measurement kept as an eight-bit read-only value.
// - Writable eight-bit supply warning threshold on the supply result scale.
// - Charge samples accumulate in 18 bits; top eight published every 10.24 s.
// - Average current compared with writable reduced-current threshold.
// - Average current compared with writable end-of-charge threshold.
// - Latest auto battery temperature kept as an eight-bit read-only value.
// - Writable battery over, resume and under temperature thresholds.
// - Writable eight-bit signed junction temperature calibration offset.
module gp_adc_regs #(
    parameter longint unsigned SLOW_CYCLES = gp_adc_pkg::SLOW_CYC,
    parameter longint unsigned FAST_CYCLES = gp_adc_pkg::FAST_CYC,
    parameter longint unsigned REFRESH_CYCLES = gp_adc_pkg::REFRESH_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic adc_start,
    output logic [3:0] adc_channel,
    input wire logic adc_done,
    input wire logic [9:0] adc_result,
    output logic aux4_current_source_on,
    output logic battery_temp_input_source_on,
    output logic aux5_comparator_enable,
    output logic [7:0] junction_offset,
    output logic battery_hot,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic hready;
        logic [31:0] hrdata;
        logic rd_wait;
        logic wr_pend;
        logic [7:0] a_idx;
        logic [3:0] chan;
        logic go;
        logic [7:0] auto_ctl;
        logic [1:0] man_lo;
        logic [7:0] man_hi;
        logic [7:0] supply_auto_result;
        logic [7:0] vdd_thr;
        logic [7:0] ich_avg;
        logic [7:0] ich_thd;
        logic [7:0] ich_end;
        logic [7:0] battery_temp_result;
        logic [7:0] battery_temp_input_hi;
        logic [7:0] battery_temp_input_rs;
        logic [7:0] battery_temp_input_lo;
        logic [7:0] t_off;
        logic [gp_adc_pkg::ACC_W-1:0] acc;
        logic hot;
        logic [gp_adc_pkg::NUM_EV-1:0] evt;
        logic [gp_adc_pkg::NUM_EV-1:0] mask;
        logic irq;
        gp_adc_pkg::conv_state_t st;
        logic [2:0] slot;
        logic seq_req;
        logic start;
        logic [3:0] adc_ch;
        logic battery_temp_input_win;
        logic battery_temp_input_src;
    } regs_state_t;

    regs_state_t q, d;
    logic seq_tick;
    logic refresh_tick;
    logic [31:0] seq_period;
    logic addr_ok;
    logic [gp_adc_pkg::NUM_EV-1:0] ev_set;
    logic [gp_adc_pkg::NUM_EV-1:0] ev_clr;
    logic [7:0] sample;
    logic [gp_adc_pkg::ACC_W:0] acc_sum;
    logic slot_en;
    logic [3:0] slot_ch;

    ////////////////////////////////////////////////////////////////////////////
    assign seq_period = q.auto_ctl[gp_adc_pkg::AC_FAST] ? 32'(FAST_CYCLES) : 32'(SLOW_CYCLES);

    period_tick #(.W(32)) u_seq_tick (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .period(seq_period),
        .tick(seq_tick)
    );

    period_tick #(.W(32)) u_refresh_tick (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .period(32'(REFRESH_CYCLES)),
        .tick(refresh_tick)
    );

    assign addr_ok = hsel && htrans[1] && hready;
    assign sample = adc_result[9:2];

    // Slot to channel map; charge and battery slots always run
    always_comb begin
        slot_en = 1'b1;
        slot_ch = gp_adc_pkg::CH_SUPPLY;
        unique case (q.slot)
            gp_adc_pkg::SLOT_SUPPLY: slot_en = q.auto_ctl[gp_adc_pkg::AC_SUPPLY];
            gp_adc_pkg::SLOT_CHARGE: slot_ch = gp_adc_pkg::CH_CHARGE;
            gp_adc_pkg::SLOT_BATTERY_TEMP_INPUT: slot_ch = gp_adc_pkg::CH_BATTERY_TEMP_INPUT;
            gp_adc_pkg::SLOT_AUX4: begin
                slot_ch = gp_adc_pkg::CH_AUX4;
                slot_en = q.auto_ctl[gp_adc_pkg::AC_AUX4];
            end
            gp_adc_pkg::SLOT_AUX5: begin
                slot_ch = gp_adc_pkg::CH_AUX5;
                slot_en = q.auto_ctl[gp_adc_pkg::AC_AUX5];
            end
            gp_adc_pkg::SLOT_AUX6: begin
                slot_ch = gp_adc_pkg::CH_AUX6;
                slot_en = q.auto_ctl[gp_adc_pkg::AC_AUX6];
            end
            default: slot_en = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        ev_set = '0;
        ev_clr = '0;
        acc_sum = {1'b0, q.acc} + (gp_adc_pkg::ACC_W + 1)'(sample);
        d.start = 1'b0;
        d.hready = 1'b1;
        d.rd_wait = 1'b0;
        d.wr_pend = 1'b0;

        // Conversion control; manual wins over a waiting auto slot
        unique case (q.st)
            gp_adc_pkg::ST_IDLE: begin
                if (q.go) begin
                    d.st = gp_adc_pkg::ST_MAN;
                    d.start = 1'b1;
                    d.adc_ch = q.chan;
                end else if (q.seq_req) begin
                    if (q.slot == gp_adc_pkg::SLOT_END) begin
                        d.seq_req = 1'b0;
                        d.slot = gp_adc_pkg::SLOT_SUPPLY;
                    end else if (slot_en) begin
                        d.st = gp_adc_pkg::ST_AUTO;
                        d.start = 1'b1;
                        d.adc_ch = slot_ch;
                        if (q.slot == gp_adc_pkg::SLOT_CHARGE) begin
                            d.battery_temp_input_win = 1'b1;
                        end
                    end else begin
                        d.slot = q.slot + 3'h1;
                    end
                end
            end
            gp_adc_pkg::ST_MAN: begin
                if (adc_done) begin
                    d.st = gp_adc_pkg::ST_IDLE;
                    d.man_lo = adc_result[1:0];
                    d.man_hi = adc_result[9:2];
                    d.go = 1'b0;
                    ev_set[gp_adc_pkg::EV_MAN] = 1'b1;
                end
            end
            gp_adc_pkg::ST_AUTO: begin
                if (adc_done) begin
                    d.st = gp_adc_pkg::ST_IDLE;
                    d.slot = q.slot + 3'h1;
                    unique case (q.slot)
                        gp_adc_pkg::SLOT_SUPPLY: begin
                            d.supply_auto_result = sample;
                            ev_set[gp_adc_pkg::EV_VDD_LOW] = sample < q.vdd_thr;
                        end
                        gp_adc_pkg::SLOT_CHARGE: begin
                            // Saturates rather than wrap in both the slow and the fast mode
                            d.acc = acc_sum[gp_adc_pkg::ACC_W] ? '1
                                : acc_sum[gp_adc_pkg::ACC_W-1:0];
                        end
                        gp_adc_pkg::SLOT_BATTERY_TEMP_INPUT: begin
                            d.battery_temp_result = sample;
                            d.battery_temp_input_win = 1'b0;
                            if (!q.hot && sample > q.battery_temp_input_hi) begin
                                d.hot = 1'b1;
                                ev_set[gp_adc_pkg::EV_HOT] = 1'b1;
                            end else if (q.hot && sample < q.battery_temp_input_rs) begin
                                d.hot = 1'b0;
                            end
                            ev_set[gp_adc_pkg::EV_COLD] = sample < q.battery_temp_input_lo;
                        end
                        default: begin
                            // Aux results are kept outside this bank
                        end
                    endcase
                end
            end
            default: d.st = gp_adc_pkg::ST_IDLE;
        endcase

        if (seq_tick) begin
            d.seq_req = 1'b1;
        end

        // Refresh restarts the window; a sample in the same cycle is dropped
        if (refresh_tick) begin
            d.ich_avg = q.acc[gp_adc_pkg::ACC_W-1 -: 8];
            d.acc = '0;
            ev_set[gp_adc_pkg::EV_ICH_RED] =
                q.acc[gp_adc_pkg::ACC_W-1 -: 8] < q.ich_thd;
            ev_set[gp_adc_pkg::EV_ICH_END] =
                q.acc[gp_adc_pkg::ACC_W-1 -: 8] < q.ich_end;
        end

        // Write data phase
        if (q.wr_pend) begin
            unique case (q.a_idx)
                gp_adc_pkg::IDX_MAN_CTL: begin
                    d.chan = hwdata[3:0];
                    // Busy manual: go write has no effect, so done always clears go
                    if (hwdata[gp_adc_pkg::GO_BIT] && q.st != gp_adc_pkg::ST_MAN) begin
                        d.go = 1'b1;
                    end
                end
                gp_adc_pkg::IDX_AUTO_CTL: d.auto_ctl = hwdata[7:0];
                gp_adc_pkg::IDX_VDD_THR: d.vdd_thr = hwdata[7:0];
                gp_adc_pkg::IDX_ICH_THD: d.ich_thd = hwdata[7:0];
                gp_adc_pkg::IDX_ICH_END: d.ich_end = hwdata[7:0];
                gp_adc_pkg::IDX_BATTERY_TEMP_INPUT_HI: d.battery_temp_input_hi = hwdata[7:0];
                gp_adc_pkg::IDX_BATTERY_TEMP_INPUT_RS: d.battery_temp_input_rs = hwdata[7:0];
                gp_adc_pkg::IDX_BATTERY_TEMP_INPUT_LO: d.battery_temp_input_lo = hwdata[7:0];
                gp_adc_pkg::IDX_T_OFF: d.t_off = hwdata[7:0];
                gp_adc_pkg::IDX_EVT: ev_clr = hwdata[gp_adc_pkg::NUM_EV-1:0];
                gp_adc_pkg::IDX_MASK: d.mask = hwdata[gp_adc_pkg::NUM_EV-1:0];
                default: begin
                end
            endcase
        end

        // Set beats clear so no event is lost
        d.evt = (q.evt & ~ev_clr) | ev_set;
        d.irq = |(d.evt & d.mask);

        // Read is answered after one wait cycle from the settled registers
        if (q.rd_wait) begin
            d.hrdata = '0;
            unique case (q.a_idx)
                gp_adc_pkg::IDX_MAN_CTL: d.hrdata[7:0] = {3'h0, q.go, q.chan};
                gp_adc_pkg::IDX_AUTO_CTL: d.hrdata[7:0] = q.auto_ctl;
                gp_adc_pkg::IDX_RES_LO: d.hrdata[7:0] = {6'h00, q.man_lo};
                gp_adc_pkg::IDX_RES_HI: d.hrdata[7:0] = q.man_hi;
                gp_adc_pkg::IDX_SUPPLY_AUTO_RESULT: d.hrdata[7:0] = q.supply_auto_result;
                gp_adc_pkg::IDX_VDD_THR: d.hrdata[7:0] = q.vdd_thr;
                gp_adc_pkg::IDX_ICH_AVG: d.hrdata[7:0] = q.ich_avg;
                gp_adc_pkg::IDX_ICH_THD: d.hrdata[7:0] = q.ich_thd;
                gp_adc_pkg::IDX_ICH_END: d.hrdata[7:0] = q.ich_end;
                gp_adc_pkg::IDX_BATTERY_TEMP_RESULT: d.hrdata[7:0] = q.battery_temp_result;
                gp_adc_pkg::IDX_BATTERY_TEMP_INPUT_HI: d.hrdata[7:0] = q.battery_temp_input_hi;
                gp_adc_pkg::IDX_BATTERY_TEMP_INPUT_RS: d.hrdata[7:0] = q.battery_temp_input_rs;
                gp_adc_pkg::IDX_BATTERY_TEMP_INPUT_LO: d.hrdata[7:0] = q.battery_temp_input_lo;
                gp_adc_pkg::IDX_T_OFF: d.hrdata[7:0] = q.t_off;
                gp_adc_pkg::IDX_EVT: d.hrdata[gp_adc_pkg::NUM_EV-1:0] = q.evt;
                gp_adc_pkg::IDX_MASK: d.hrdata[gp_adc_pkg::NUM_EV-1:0] = q.mask;
                default: d.hrdata = '0;
            endcase
        end

        // Address phase
        if (addr_ok) begin
            d.a_idx = haddr[9:2];
            if (hwrite) begin
                d.wr_pend = 1'b1;
            end else begin
                d.rd_wait = 1'b1;
                d.hready = 1'b0;
            end
        end

        d.battery_temp_input_src = d.auto_ctl[gp_adc_pkg::AC_BATTERY_TEMP_INPUT_ON] | d.battery_temp_input_win;
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            q <= '0;
            q.hready <= 1'b1;
            q.st <= gp_adc_pkg::ST_IDLE;
            q.mask <= gp_adc_pkg::RST_MASK;
            q.auto_ctl <= gp_adc_pkg::RST_BYTE;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign hreadyout = q.hready;
    assign hresp = 1'b0;
    assign hrdata = q.hrdata;
    assign adc_start = q.start;
    assign adc_channel = q.adc_ch;
    assign aux4_current_source_on = q.auto_ctl[gp_adc_pkg::AC_AUX4_SRC];
    assign battery_temp_input_source_on = q.battery_temp_input_src;
    assign aux5_comparator_enable = q.auto_ctl[gp_adc_pkg::AC_COMP];
    assign junction_offset = q.t_off;
    assign battery_hot = q.hot;
    assign irq = q.irq;

    ////////////////////////////////////////////////////////////////////////////
    a_man_channel: assert property (@(posedge core_clk) disable iff (!reset_n)
        (q.st == gp_adc_pkg::ST_IDLE && q.go) |=> (adc_start && adc_channel == $past(q.chan)))
        else $error("manual start on wrong channel");
    a_go_result: assert property (@(posedge core_clk) disable iff (!reset_n)
        (q.st == gp_adc_pkg::ST_MAN && adc_done)
        |=> (!q.go && {q.man_hi, q.man_lo} == $past(adc_result)))
        else $error("manual result not coherent with go clear");
    a_supply_skip: assert property (@(posedge core_clk) disable iff (!reset_n)
        (adc_start && q.st == gp_adc_pkg::ST_AUTO && adc_channel == gp_adc_pkg::CH_SUPPLY)
        |-> $past(q.auto_ctl[gp_adc_pkg::AC_SUPPLY]))
        else $error("supply measured while disabled");
    a_aux_skip: assert property (@(posedge core_clk) disable iff (!reset_n)
        (adc_start && q.st == gp_adc_pkg::ST_AUTO && adc_channel == gp_adc_pkg::CH_AUX6)
        |-> $past(q.auto_ctl[gp_adc_pkg::AC_AUX6]))
        else $error("aux six measured while disabled");
    a_battery_temp_input_source: assert property (@(posedge core_clk) disable iff (!reset_n)
        (adc_start && q.st == gp_adc_pkg::ST_AUTO && adc_channel == gp_adc_pkg::CH_BATTERY_TEMP_INPUT)
        |-> battery_temp_input_source_on)
        else $error("battery source off during its measurement");
    a_read_wait: assert property (@(posedge core_clk) disable iff (!reset_n)
        (addr_ok && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_ro_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
        ($past(q.rd_wait) && q.a_idx == gp_adc_pkg::IDX_MAN_CTL) |-> hrdata[7:5] == 3'h0)
        else $error("manual control upper bits not zero");
    a_hot_event: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(q.hot) |-> q.evt[gp_adc_pkg::EV_HOT])
        else $error("hot flag set without event");
    a_avg_publish: assert property (@(posedge core_clk) disable iff (!reset_n)
        refresh_tick |=> (q.ich_avg == $past(q.acc[gp_adc_pkg::ACC_W-1 -: 8]) && q.acc == '0))
        else $error("average not published on refresh");
    a_irq_level: assert property (@(posedge core_clk) disable iff (!reset_n)
        irq == |(q.evt & q.mask))
        else $error("interrupt level mismatch");
endmodule
`default_nettype wire

// File: adc_conv_model.sv
`default_nettype none
module adc_conv_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic adc_start,
    input wire logic [3:0] adc_channel,
    input wire logic [9:0] value,
    input wire logic slow,
    output logic adc_done,
    output logic [9:0] adc_result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [3:0] cnt;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            busy <= 1'h0;
            cnt <= 4'h0;
            adc_done <= 1'h0;
            adc_result <= 10'h0;
        end else begin
            adc_done <= 1'h0;
            // Result toggles when not valid, so a stale read shows up
            adc_result <= ~adc_result;
            if (adc_start) begin
                busy <= 1'h1;
                cnt <= slow ? 4'hC : 4'h0;
            end else if (busy && cnt == 4'h0) begin
                busy <= 1'h0;
                adc_done <= 1'h1;
                adc_result <= value;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: test_gp_adc_control_regs.sv
`default_nettype none
module test_gp_adc_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, reset_n = 0, hsel = 0, hwrite = 0, slow = 0;
    logic [31:0] haddr = '0, hwdata = '0, r;
    logic [1:0] htrans = '0;
    logic [9:0] value = 10'h100;
    wire logic hreadyout, hresp, adc_start, adc_done, aux4, tsrc, comp, hot, irq;
    wire logic [31:0] hrdata;
    wire logic [3:0] ch;
    wire logic [9:0] res;
    wire logic [7:0] joff;
    int fail_count = 0, num_checks = 0, cyc = 0, n[16];
    // Short periods keep the run small; expectations use these figures
    gp_adc_regs #(.SLOW_CYCLES(200), .FAST_CYCLES(50), .REFRESH_CYCLES(3000)) uut (
        .core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .adc_start, .adc_channel(ch),
        .adc_done, .adc_result(res), .aux4_current_source_on(aux4), .battery_temp_input_source_on(tsrc),
        .aux5_comparator_enable(comp), .junction_offset(joff), .battery_hot(hot), .irq);
    adc_conv_model m (.core_clk, .reset_n, .adc_start, .adc_channel(ch), .value, .slow,
        .adc_done, .adc_result(res));
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #2 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc == 20000) begin
        fail_count++;
        summarize();
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    // Address held until hready, data held until hready again
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'h1; htrans <= 2'h2; hwrite <= w; haddr <= {22'h0, i, 2'h0};
        do @(posedge core_clk); while (hreadyout !== 1'h1);
        hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'h1);
        r = hrdata;
        #1;
    endtask
    task automatic rc(input string s, input logic [7:0] i, input logic [31:0] e);
        bus(1'h0, i, '0);
        chk(s, r, e);
    endtask
    task automatic wst(input logic [3:0] c);
        int j;
        for (j = 0; j < 600 && !(adc_start === 1'h1 && ch === c); j++) @(posedge core_clk);
        chk("start seen", 32'(j < 600), 32'h1);
    endtask
    task automatic cnt();
        n = '{default: 0};
        repeat (1000) begin
            @(posedge core_clk);
            if (adc_start === 1'h1) n[ch]++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] rw[8] = '{8'h52, 8'h56, 8'h58, 8'h59, 8'h5B, 8'h5C, 8'h5D, 8'h5E};
        chk("irq", irq, 1'h0);
        chk("hresp", hresp, 1'h0);
        foreach (rw[i]) bus(1'h1, rw[i], 32'h80 + i);
        foreach (rw[i]) rc("rw reg", rw[i], 32'h80 + i);
        chk("offset", joff, 8'h87);
        chk("comparator", comp, 1'h1);
        bus(1'h1, 8'h52, 32'h10);
        chk("aux4 source", aux4, 1'h1);
        chk("comparator", comp, 1'h0);
        bus(1'h1, 8'h52, 32'h0);
        chk("aux4 source", aux4, 1'h0);
        // Read-only and unmapped places must swallow writes
        foreach (rw[i]) if (i < 5) bus(1'h1, 8'(8'h53 + i), 32'hFF);
        bus(1'h1, 8'h51, 32'hE0);
        bus(1'h1, 8'h70, 32'hFF);
        rc("man ctl", 8'h51, 32'h0);
        rc("res low", 8'h53, 32'h0);
        rc("res high", 8'h54, 32'h0);
        rc("supply res", 8'h55, 32'h0);
        rc("avg", 8'h57, 32'h0);
        rc("unmapped", 8'h70, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_manual();
        logic [3:0] cs[2] = '{4'h3, 4'h8};
        bus(1'h1, 8'h60, 32'h1);
        bus(1'h1, 8'h5F, 32'h3F);
        chk("irq", irq, 1'h0);
        foreach (cs[i]) begin
            slow <= i[0];
            value <= 10'h2C5 + cs[i];
            bus(1'h1, 8'h51, {24'h0, 4'hF, cs[i]});
            wst(cs[i]);
            for (int j = 0; j < 40; j++) begin
                bus(1'h0, 8'h51, '0);
                if (r[4] === 1'h0) break;
            end
            chk("go clear", r, {28'h0, cs[i]});
            rc("res low", 8'h53, {30'h0, value[1:0]});
            rc("res high", 8'h54, {24'h0, value[9:2]});
            chk("irq", irq, 1'h1);
            bus(1'h1, 8'h5F, 32'h1);
            chk("irq", irq, 1'h0);
        end
        slow <= 1'h0;
        $display("test manual done");
    endtask
    task automatic t_auto();
        value <= 10'h100;
        bus(1'h1, 8'h56, 32'hFF);
        bus(1'h1, 8'h60, 32'h2);
        bus(1'h1, 8'h52, 32'h1);
        bus(1'h1, 8'h5F, 32'h3F);
        wst(gp_adc_pkg::CH_SUPPLY);
        chk("battery_temp_input src", tsrc, 1'h0);
        wst(gp_adc_pkg::CH_BATTERY_TEMP_INPUT);
        chk("battery_temp_input src", tsrc, 1'h1);
        repeat (30) @(posedge core_clk);
        chk("battery_temp_input src", tsrc, 1'h0);
        rc("supply res", 8'h55, 32'h40);
        rc("battery_temp_result", 8'h5A, 32'h40);
        chk("low supply irq", irq, 1'h1);
        bus(1'h1, 8'h52, 32'h2E);
        chk("battery_temp_input src", tsrc, 1'h1);
        cnt();
        chk("supply off", n[0], 0);
        chk("aux4", 32'(n[4] >= 4), 1);
        chk("aux5", 32'(n[5] >= 4), 1);
        chk("aux6", 32'(n[6] >= 4), 1);
        chk("slow rate", 32'(n[1] <= 6), 1);
        bus(1'h1, 8'h52, 32'h41);
        cnt();
        chk("fast rate", 32'(n[1] >= 15), 1);
        chk("aux4 off", n[4], 0);
        bus(1'h1, 8'h52, 32'h0);
        $display("test auto done");
    endtask
    task automatic t_avg();
        int j;
        bus(1'h1, 8'h58, 32'h10);
        bus(1'h1, 8'h59, 32'h10);
        bus(1'h1, 8'h60, 32'hC);
        bus(1'h1, 8'h5F, 32'h3F);
        for (j = 0; j < 4000 && irq !== 1'h1; j++) @(posedge core_clk);
        chk("avg irq", irq, 1'h1);
        bus(1'h0, 8'h57, '0);
        chk("avg small", 32'(r < 32'h10), 1);
        bus(1'h0, 8'h5F, '0);
        chk("avg events", r[3:2], 2'h3);
        // Samples sit at 0x40: above the high limit, above the resume level
        bus(1'h1, 8'h5C, 32'h30);
        bus(1'h1, 8'h5B, 32'h3F);
        for (j = 0; j < 600 && hot !== 1'h1; j++) @(posedge core_clk);
        chk("hot", hot, 1'h1);
        repeat (250) @(posedge core_clk);
        chk("hot held", hot, 1'h1);
        bus(1'h0, 8'h5F, '0);
        chk("hot event", r[4], 1'h1);
        bus(1'h1, 8'h5C, 32'h41);
        for (j = 0; j < 600 && hot !== 1'h0; j++) @(posedge core_clk);
        chk("hot cleared", hot, 1'h0);
        $display("test average done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'h1;
        t_regs();
        t_manual();
        t_auto();
        t_avg();
        summarize();
    end
endmodule
`default_nettype wire
